/* logic/anp_pkg.sv */
/*
 Package for the auto-negotiation next-page register block: register
 offsets, field positions, reset values and the packed carriers.
 Assumes a 16-bit register port with word indices as addresses.
*/
package anp_pkg;
   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [4:0] ADDR_EXP = 5'h06;
   localparam logic [4:0] ADDR_NPTX = 5'h07;
   localparam logic [4:0] ADDR_NPRX = 5'h08;
   localparam logic [4:0] ADDR_CFG = 5'h10;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h18;
   localparam logic [4:0] ADDR_IRQ_MASK = 5'h19;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int EXP_PARTNER_AN = 0;
   localparam int EXP_PAGE_RX = 1;
   localparam int EXP_LOCAL_NP = 2;
   localparam int EXP_PARTNER_NP = 3;
   localparam int EXP_PD_FAULT = 4;
   localparam int EXP_BASE_PAGE = 5;
   localparam int CFG_ALT_NP = 1;
   localparam int IRQ_PAGE = 0;
   localparam int IRQ_FAULT = 1;
   localparam int IRQ_BASE = 2;
   localparam int PAGE_MORE = 15;
   localparam int PAGE_ACK = 14;
   localparam int PAGE_MP = 13;
   localparam int PAGE_COMPLY = 12;
   localparam int PAGE_TOGGLE = 11;
   localparam int PAGE_CODE_MSB = 10;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [10:0] NPTX_CODE_RST = 11'h001;
   localparam logic NPTX_MP_RST = 1'b1;
   localparam logic LOCAL_NP_ABLE = 1'b1;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic morePagesFollow;
      logic ack;
      logic messagePageFlag;
      logic willComplyFlag;
      logic toggle;
      logic [10:0] code;
   } anp_page_t;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } anp_bus_t;

   typedef struct packed {
      logic basePage;
      logic pdFault;
      logic pageRx;
      logic partnerAnAble;
      logic partnerNpAble;
      logic transmitDisable;
   } anp_link_t;
endpackage

/* logic/anp_latch_flag.sv */
/*
 One latching-high status flag: set by an event, cleared by a read
 or by a forced clear; a set in the clearing cycle wins.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module anp_latch_flag (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic setEv,
   input wire logic clrEv,
   output logic flag
);
   // sticky bit, set over clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (setEv) begin
         flag <= 1'b1;
      end else if (clrEv) begin
         flag <= 1'b0;
      end
   end
endmodule

/* logic/anp_next_page_regs.sv */
/*
 Register bank for auto-negotiation expansion status, next-page
 transmit word and partner next-page receive word, with interrupts.
 Word index 6 holds latching status and ability bits, 7 the word
 the local side sends next, 8 the last word taken from the partner,
 0x10 the alternate next-page switch, 0x18 and 0x19 the interrupt
 status and mask.
 Assumes a synchronous register port and link-side event inputs from
 the negotiation engine, all on clk; read data stand for one cycle
 after the strobe and are zero otherwise.
*/
`timescale 1ns/100ps

// Summary of operation
// - base-page flag latches, used when alternate enabled
// - parallel fault flag latches until read
// - page-received set on stored page, read clears
// - alternate mode also clears on page-rx false, txdisable
// - local next-page-able reads constant one
// - partner autoneg and next-page ability read-only
// - transmit more-pages flag writable, resets zero
// - reserved transmit bit read-only, reads zero
// - transmit message-page flag writable, resets one
// - transmit will-comply flag writable, resets zero
// - transmit toggle writable, resets zero
// - received more-pages flag read-only, resets zero
// - received acknowledge read-only, resets zero
// - received message-page flag read-only, resets zero
// - received will-comply flag read-only, resets zero
// - received toggle read-only, resets zero
// - config bit enables alternate next-page behaviour
module anp_next_page_regs (
   input wire logic clk,
   input wire logic rst_n,
   input wire anp_pkg::anp_bus_t bus,
   output logic [15:0] rdata,
   input wire anp_pkg::anp_link_t link,
   input wire logic rxPageStore,
   input wire anp_pkg::anp_page_t rxPage,
   output anp_pkg::anp_page_t txPage,
   output logic altNextPageEnable,
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // stored words and configuration
   anp_pkg::anp_page_t txPage_r;
   anp_pkg::anp_page_t rxPage_r;
   logic altNp_r;
   logic partnerAn_r;
   logic partnerNp_r;

   // latching flags and edge history
   logic basePageFlag;
   logic pdFaultFlag;
   logic pageRxFlag;
   logic basePrev_r;
   logic pdPrev_r;
   logic pageRxPrev_r;
   logic txDisPrev_r;
   logic baseSet;
   logic faultSet;
   logic pageRxFall;
   logic txDisRise;
   logic pageClr;

   // interrupt status and mask
   logic [2:0] irqStat_r;
   logic [2:0] irqStat_nxt;
   logic [2:0] irqMask_r;
   logic [2:0] irqEv;
   logic [2:0] statClr;
   logic irqLevel;
   logic irq_r;

   // bus decodes and read path
   logic [15:0] rdata_nxt;
   logic expRead;
   logic wrNptx;
   logic wrCfg;
   logic wrStat;
   logic wrMask;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // address match used by several decodes
   function automatic logic hit(input anp_pkg::anp_bus_t b, input logic [4:0] a);
      hit = (b.addr == a);
   endfunction

   // page carrier to register word, reserved position forced low on request
   function automatic logic [15:0] pageWord(input anp_pkg::anp_page_t p, input logic hideAck);
      logic [15:0] v;
      v = 16'h0000;
      v[anp_pkg::PAGE_MORE] = p.morePagesFollow;
      v[anp_pkg::PAGE_ACK] = p.ack & ~hideAck;
      v[anp_pkg::PAGE_MP] = p.messagePageFlag;
      v[anp_pkg::PAGE_COMPLY] = p.willComplyFlag;
      v[anp_pkg::PAGE_TOGGLE] = p.toggle;
      v[anp_pkg::PAGE_CODE_MSB:0] = p.code;
      return v;
   endfunction

   // ----------------------------------------------------------------
   // bus decodes
   // ----------------------------------------------------------------
   // one strobe per register that a bus access changes
   assign expRead = bus.rd && hit(bus, anp_pkg::ADDR_EXP);
   assign wrNptx = bus.wr && hit(bus, anp_pkg::ADDR_NPTX);
   assign wrCfg = bus.wr && hit(bus, anp_pkg::ADDR_CFG);
   assign wrStat = bus.wr && hit(bus, anp_pkg::ADDR_IRQ_STAT);
   assign wrMask = bus.wr && hit(bus, anp_pkg::ADDR_IRQ_MASK);

   // ----------------------------------------------------------------
   // edge history of link inputs
   // ----------------------------------------------------------------
   // previous levels for rising and falling detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         basePrev_r <= 1'b0;
         pdPrev_r <= 1'b0;
         pageRxPrev_r <= 1'b0;
         txDisPrev_r <= 1'b0;
      end else begin
         basePrev_r <= link.basePage;
         pdPrev_r <= link.pdFault;
         pageRxPrev_r <= link.pageRx;
         txDisPrev_r <= link.transmitDisable;
      end
   end

   // ----------------------------------------------------------------
   // link events
   // ----------------------------------------------------------------
   // base page only counts while the alternate feature is on
   assign baseSet = altNp_r && link.basePage && !basePrev_r;
   // fault latches on its rising edge
   assign faultSet = link.pdFault && !pdPrev_r;
   // alternate clears: page-rx going false, transmit disable rising
   assign pageRxFall = pageRxPrev_r && !link.pageRx;
   assign txDisRise = link.transmitDisable && !txDisPrev_r;

   // ----------------------------------------------------------------
   // latching status flags
   // ----------------------------------------------------------------
   // base page latches high while alternate mode is on
   anp_latch_flag u_base (
      .clk(clk),
      .rst_n(rst_n),
      .setEv(baseSet),
      .clrEv(expRead),
      .flag(basePageFlag)
   );

   // parallel detection fault held until read
   anp_latch_flag u_fault (
      .clk(clk),
      .rst_n(rst_n),
      .setEv(faultSet),
      .clrEv(expRead),
      .flag(pdFaultFlag)
   );

   // extra clears of page received in alternate mode
   assign pageClr = expRead || (altNp_r && (pageRxFall || txDisRise));

   // page received set when a word is stored
   anp_latch_flag u_page (
      .clk(clk),
      .rst_n(rst_n),
      .setEv(rxPageStore),
      .clrEv(pageClr),
      .flag(pageRxFlag)
   );

   // ----------------------------------------------------------------
   // partner abilities and received page
   // ----------------------------------------------------------------
   // partner ability bits follow the engine
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         partnerAn_r <= 1'b0;
         partnerNp_r <= 1'b0;
      end else begin
         partnerAn_r <= link.partnerAnAble;
         partnerNp_r <= link.partnerNpAble;
      end
   end

   // received word loads when the engine stores it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxPage_r <= '0;
      end else if (rxPageStore) begin
         rxPage_r <= rxPage;
      end
   end

   // ----------------------------------------------------------------
   // writable registers
   // ----------------------------------------------------------------
   // transmit next-page word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txPage_r.morePagesFollow <= 1'b0;
         txPage_r.ack <= 1'b0;
         txPage_r.messagePageFlag <= anp_pkg::NPTX_MP_RST;
         txPage_r.willComplyFlag <= 1'b0;
         txPage_r.toggle <= 1'b0;
         txPage_r.code <= anp_pkg::NPTX_CODE_RST;
      end else if (wrNptx) begin
         // ack position is reserved and never written
         txPage_r.morePagesFollow <= bus.wdata[anp_pkg::PAGE_MORE];
         txPage_r.messagePageFlag <= bus.wdata[anp_pkg::PAGE_MP];
         txPage_r.willComplyFlag <= bus.wdata[anp_pkg::PAGE_COMPLY];
         txPage_r.toggle <= bus.wdata[anp_pkg::PAGE_TOGGLE];
         txPage_r.code <= bus.wdata[anp_pkg::PAGE_CODE_MSB:0];
      end
   end

   // configuration bit for alternate next-page mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         altNp_r <= 1'b0;
      end else if (wrCfg) begin
         altNp_r <= bus.wdata[anp_pkg::CFG_ALT_NP];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // events mirror the flag set conditions
   assign irqEv = {baseSet, faultSet, rxPageStore};

   // write-one clears apply only to the status index
   assign statClr = wrStat ? bus.wdata[2:0] : 3'h0;

   // sticky status, set wins over clear
   always_comb begin
      irqStat_nxt = (irqStat_r & ~statClr) | irqEv;
   end

   // level for the output flop, same view as the status update
   assign irqLevel = |(irqStat_nxt & irqMask_r);

   // status register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_r <= 3'h0;
      end else begin
         irqStat_r <= irqStat_nxt;
      end
   end

   // interrupt mask, one enables
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqMask_r <= 3'h0;
      end else if (wrMask) begin
         irqMask_r <= bus.wdata[2:0];
      end
   end

   // registered interrupt level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irqLevel;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // read mux, unmapped reads zero
   always_comb begin
      rdata_nxt = 16'h0000;
      case (bus.addr)
         anp_pkg::ADDR_EXP: begin
            rdata_nxt[anp_pkg::EXP_BASE_PAGE] = basePageFlag;
            rdata_nxt[anp_pkg::EXP_PD_FAULT] = pdFaultFlag;
            rdata_nxt[anp_pkg::EXP_PARTNER_NP] = partnerNp_r;
            rdata_nxt[anp_pkg::EXP_LOCAL_NP] = anp_pkg::LOCAL_NP_ABLE;
            rdata_nxt[anp_pkg::EXP_PAGE_RX] = pageRxFlag;
            rdata_nxt[anp_pkg::EXP_PARTNER_AN] = partnerAn_r;
         end
         anp_pkg::ADDR_NPTX: begin
            rdata_nxt = pageWord(txPage_r, 1'b1);
         end
         anp_pkg::ADDR_NPRX: begin
            rdata_nxt = pageWord(rxPage_r, 1'b0);
         end
         anp_pkg::ADDR_CFG: begin
            rdata_nxt[anp_pkg::CFG_ALT_NP] = altNp_r;
         end
         anp_pkg::ADDR_IRQ_STAT: begin
            rdata_nxt[2:0] = irqStat_r;
         end
         anp_pkg::ADDR_IRQ_MASK: begin
            rdata_nxt[2:0] = irqMask_r;
         end
         default: begin
            rdata_nxt = 16'h0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // read register
   // ----------------------------------------------------------------
   // read data stands one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (bus.rd) begin
         rdata <= rdata_nxt;
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // outputs straight from flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         altNextPageEnable <= 1'b0;
      end else begin
         altNextPageEnable <= altNp_r;
      end
   end

   assign txPage = txPage_r;
   assign irq = irq_r;
endmodule

/* tb/anp_next_page_regs_checker.sv */
/* port checker for the next-page register bank
   assumes a bind onto anp_next_page_regs and a single clock */
`timescale 1ns/100ps
module anp_next_page_regs_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire anp_pkg::anp_bus_t bus,
   input wire logic [15:0] rdata,
   input wire anp_pkg::anp_link_t link,
   input wire logic rxPageStore,
   input wire anp_pkg::anp_page_t rxPage,
   input wire anp_pkg::anp_page_t txPage,
   input wire logic altNextPageEnable,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------------------------------
   // decodes and step sequences
   // ----------------------------------------------------------------
   wire rdExp = bus.rd && bus.addr == anp_pkg::ADDR_EXP;
   wire wrMask = bus.wr && bus.addr == anp_pkg::ADDR_IRQ_MASK;
   sequence storeThenRead;
      rxPageStore ##1 (bus.rd && bus.addr == anp_pkg::ADDR_NPRX && !rxPageStore);
   endsequence
   sequence quietTwoReads;
      (!link.pdFault && !rxPageStore) ##1 (rdExp && !link.pdFault && !rxPageStore) [*2];
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   local_np_a: assert property (rdExp |=> rdata[2] == 1'b1)
      else $error("local next-page ability not reported");
   reserved_bit_a: assert property (bus.rd && bus.addr == anp_pkg::ADDR_NPTX |=> !rdata[14])
      else $error("reserved transmit bit read as one");
   rx_word_load_a: assert property (storeThenRead |=> rdata == $past(rxPage, 2))
      else $error("received word not loaded");
   page_set_a: assert property (rxPageStore && !altNextPageEnable ##1 rdExp |=> rdata[1])
      else $error("page flag not set by stored page");
   read_clear_a: assert property (quietTwoReads |=> !rdata[4] && !rdata[1])
      else $error("latched flag survived a read");
   tx_write_a: assert property (bus.wr && bus.addr == anp_pkg::ADDR_NPTX
      |=> txPage == ($past(bus.wdata) & 16'hBFFF))
      else $error("transmit word not taken from write");
   partner_able_a: assert property (rdExp && $stable(link.partnerAnAble)
      && $stable(link.partnerNpAble) |=> rdata[0] == $past(link.partnerAnAble)
      && rdata[3] == $past(link.partnerNpAble))
      else $error("partner ability bits wrong");
   irq_masked_a: assert property (wrMask && bus.wdata == 16'h0000 ##1 !wrMask |=> !irq)
      else $error("interrupt high with all masked");
endmodule

/* tb/anp_partner_model.sv */
/* link partner model: hands received pages to the block
   assumes one request pulse per page from the bench on clk */
`timescale 1ns/100ps
module anp_partner_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sendReq,
   input wire anp_pkg::anp_page_t sendWord,
   output logic rxPageStore,
   output anp_pkg::anp_page_t rxPage
);
   // one store pulse per request; word changes every cycle otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rxPageStore <= 1'b0;
         rxPage <= 16'hFFFF;
      end else begin
         rxPageStore <= sendReq;
         rxPage <= sendReq ? sendWord : ~rxPage;
      end
   end
endmodule

/* tb/anp_next_page_regs_tb_top.sv */
/* self-checking bench for the next-page register bank
   assumes the checker and partner model are compiled before it */
`timescale 1ns/100ps
module anp_next_page_regs_tb_top;
   logic clk;
   logic rst_n;
   anp_pkg::anp_bus_t busIn;
   anp_pkg::anp_link_t link;
   anp_pkg::anp_page_t sendWord;
   anp_pkg::anp_page_t rxPage;
   anp_pkg::anp_page_t txPage;
   logic [15:0] rdata;
   logic sendReq;
   logic rxPageStore;
   logic altNextPageEnable;
   logic irq;
   logic [31:0] seed;
   logic [15:0] d;
   logic [15:0] d2;
   logic [15:0] w;
   int fails;
   int nTests;

   anp_next_page_regs i_dut (.clk(clk), .rst_n(rst_n), .bus(busIn), .rdata(rdata),
      .link(link), .rxPageStore(rxPageStore), .rxPage(rxPage), .txPage(txPage),
      .altNextPageEnable(altNextPageEnable), .irq(irq));
   anp_partner_model i_partner (.clk(clk), .rst_n(rst_n), .sendReq(sendReq),
      .sendWord(sendWord), .rxPageStore(rxPageStore), .rxPage(rxPage));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [15:0] expTx(input logic [15:0] v);
      return v & 16'hBFFF;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      nTests++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      @(posedge clk);
      busIn.wr <= 1'b1;
      busIn.addr <= a;
      busIn.wdata <= v;
      @(posedge clk);
      busIn.wr <= 1'b0;
   endtask
   task automatic rd2(input logic [4:0] a, output logic [15:0] v1, output logic [15:0] v2);
      @(posedge clk);
      busIn.rd <= 1'b1;
      busIn.addr <= a;
      @(posedge clk);
      @(negedge clk);
      v1 = rdata;
      @(posedge clk);
      busIn.rd <= 1'b0;
      @(negedge clk);
      v2 = rdata;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [15:0] e);
      @(posedge clk);
      busIn.rd <= 1'b1;
      busIn.addr <= a;
      @(posedge clk);
      busIn.rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task automatic send(input logic [15:0] v);
      @(posedge clk);
      sendReq <= 1'b1;
      sendWord <= v;
      @(posedge clk);
      sendReq <= 1'b0;
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // clock and hang limit
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      busIn = '0;
      link = '0;
      sendReq = 1'b0;
      sendWord = '0;
      seed = 32'h000161D9;
      fails = 0;
      nTests = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, read-only writes, unmapped slot
      rd2(anp_pkg::ADDR_EXP, d, d2);
      chk(d, 16'h0004);
      chk(d2, 16'h0004);
      rdc(anp_pkg::ADDR_NPTX, 16'h2001);
      rdc(anp_pkg::ADDR_NPRX, 16'h0000);
      wr(anp_pkg::ADDR_EXP, 16'hFFFF);
      rdc(anp_pkg::ADDR_EXP, 16'h0004);
      rdc(5'h1F, 16'h0000);
      // transmit word: corners then random, reserved bit included
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         w = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : seed[15:0];
         wr(anp_pkg::ADDR_NPTX, w);
         wr(anp_pkg::ADDR_NPRX, ~w);
         rdc(anp_pkg::ADDR_NPTX, expTx(w));
         chk(txPage, expTx(w));
         rdc(anp_pkg::ADDR_NPRX, 16'h0000);
      end
      // received page sets flag, read clears it
      seed = xs(seed);
      w = seed[15:0];
      send(w);
      rd2(anp_pkg::ADDR_EXP, d, d2);
      chk(d & 16'h0002, 16'h0002);
      chk(d2 & 16'h0002, 16'h0000);
      rdc(anp_pkg::ADDR_NPRX, w);
      // fault and abilities; base page ignored while alternate off
      @(posedge clk);
      link <= 6'b110110;
      rd2(anp_pkg::ADDR_EXP, d, d2);
      chk(d, 16'h001D);
      chk(d2, 16'h000D);
      // alternate mode: base page latches
      wr(anp_pkg::ADDR_CFG, 16'h0002);
      @(posedge clk);
      link.basePage <= 1'b0;
      @(posedge clk);
      link.basePage <= 1'b1;
      rd2(anp_pkg::ADDR_EXP, d, d2);
      chk(d, 16'h002D);
      chk(d2, 16'h000D);
      chk({15'h0000, altNextPageEnable}, 16'h0001);
      // alternate clears: page-rx false, transmit disable, neither
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         link.pageRx <= 1'b1;
         link.transmitDisable <= 1'b0;
         send(w);
         @(posedge clk);
         link.pageRx <= (k != 0);
         link.transmitDisable <= (k == 1);
         rd2(anp_pkg::ADDR_EXP, d, d2);
         chk(d & 16'h0002, (k == 2) ? 16'h0002 : 16'h0000);
      end
      // interrupt: raise, status, write-one clear, mask
      wr(anp_pkg::ADDR_IRQ_STAT, 16'h0007);
      wr(anp_pkg::ADDR_IRQ_MASK, 16'h0007);
      seed = xs(seed);
      send(seed[15:0]);
      rdc(anp_pkg::ADDR_NPRX, seed[15:0]);
      chk({15'h0000, irq}, 16'h0001);
      rdc(anp_pkg::ADDR_IRQ_STAT, 16'h0001);
      wr(anp_pkg::ADDR_IRQ_STAT, 16'h0001);
      rdc(anp_pkg::ADDR_IRQ_STAT, 16'h0000);
      chk({15'h0000, irq}, 16'h0000);
      wr(anp_pkg::ADDR_IRQ_MASK, 16'h0000);
      send(w);
      rdc(anp_pkg::ADDR_IRQ_STAT, 16'h0001);
      chk({15'h0000, irq}, 16'h0000);
      stop_test();
   end
endmodule

bind anp_next_page_regs anp_next_page_regs_checker i_chk (.clk(clk), .rst_n(rst_n),
   .bus(bus), .rdata(rdata), .link(link), .rxPageStore(rxPageStore), .rxPage(rxPage),
   .txPage(txPage), .altNextPageEnable(altNextPageEnable), .irq(irq));
